//--- src/tnp_pkg.sv
// Purpose: constants shared by the three-nibble port block
// Assumes: 4-bit ports, config operand is 5 bits (bit 4 = pull-low enable)
// Notes: function selects are build-time parameters of the top module
package tnp_pkg;
    localparam int PORT_W = 4;
    localparam int CFG_PULL_BIT = 4;
    localparam logic [3:0] DIR_RESET = 4'h0;
    localparam logic [3:0] LATCH_RESET = 4'h0;
    localparam logic PULL_RESET = 1'b1;
    localparam logic [4:0] CFG_C_PULL = 5'h10;
    localparam logic [4:0] CFG_C_HOLD = 5'h00;
    localparam int SER_DATA0 = 0;
    localparam int SER_DATA1 = 1;
    localparam int SER_CONST = 2;
    localparam int SER_CLK = 3;
    localparam int OSC_BIT = 1;
    localparam int DEB_STABLE = 2;
    // Pin function selects
    typedef enum logic [1:0] {TNP_FN_LCD, TNP_FN_IO, TNP_FN_ALT} tnp_fn_t;
endpackage : tnp_pkg

//--- src/tnp_ports.sv
// Purpose: three 4-bit bidirectional ports with direction, latch, pull-low
// Assumes: instruction strobes are one-cycle pulses from the core, same clock
// Notes: pins are split into in/out/oe; pulls are reported as enable levels
`timescale 1ns/1ps
`default_nettype none
module tnp_ports
    import tnp_pkg::*;
#(
    parameter tnp_fn_t FN_A [4] = '{default: TNP_FN_IO},
    parameter tnp_fn_t FN_B [4] = '{default: TNP_FN_IO},
    parameter tnp_fn_t FN_C [4] = '{default: TNP_FN_IO},
    parameter bit PULL_A_EN = 1'b1,
    parameter bit PULL_B_EN = 1'b1,
    parameter bit PULL_C_EN = 1'b1,
    parameter bit HOLD_C_OPT = 1'b1
) (
    input wire logic clk, // Core clock
    input wire logic rst_n, // Sync reset, active low
    input wire logic [4:0] cfg_data, // Config operand: dir[3:0], pull[4]
    input wire logic port_a_config, // Config strobes
    input wire logic port_b_config, // Config strobe B
    input wire logic port_c_config, // Config strobe C
    input wire logic [3:0] wr_data, // Data-memory nibble to write
    input wire logic port_a_write, // Write strobe A
    input wire logic port_b_write, // Write strobe B
    input wire logic port_c_write, // Write strobe C
    input wire logic port_a_serial_emit, // Serial emit strobe
    input wire logic [1:0] ser_data, // Data-memory bits for serial
    input wire logic ser_const, // Constant operand bit
    input wire logic converter_en, // Converter counting active
    input wire logic debounce_tick, // Debounce clock pulse
    input wire logic debounce_clear, // Clears release flag
    input wire logic [3:0] debounce_sel, // Port C inputs watched
    input wire logic [3:0] pin_a_in, // Pin levels A
    input wire logic [3:0] pin_b_in, // Pin levels B
    input wire logic [3:0] pin_c_in, // Pin levels C
    output logic [3:0] pin_a_out, // Drive values A
    output logic [3:0] pin_b_out, // Drive values B
    output logic [3:0] pin_c_out, // Drive values C
    output logic [3:0] pin_a_oe, // Output enables A
    output logic [3:0] pin_b_oe, // Output enables B
    output logic [3:0] pin_c_oe, // Output enables C
    output logic [3:0] pull_a_on, // Pull-low active A
    output logic [3:0] pull_b_on, // Pull-low active B
    output logic [3:0] pull_c_on, // Pull-low active C
    output logic [3:0] hold_c_on, // Hold device active C
    output logic [3:0] rd_a, // Read value A
    output logic [3:0] rd_b, // Read value B
    output logic [3:0] rd_c, // Read value C
    output logic debounce_release_flag // Halt-release request
);
    logic [3:0] sa1_reg, sa2_reg, sb1_reg, sb2_reg, sc1_reg, sc2_reg;
    logic [3:0] dir_a_reg, dir_b_reg, dir_c_reg;
    logic [3:0] lat_a_reg, lat_b_reg, lat_c_reg;
    logic pull_a_reg, pull_b_reg, pull_c_reg;
    logic ser_clk_reg;
    logic [3:0] deb_ref_reg;
    logic [1:0] deb_cnt_reg;
    logic [3:0] io_a, io_b, io_c;
    logic hold_present;

    // Mask of pins still serving port function
    function automatic logic [3:0] io_mask(input tnp_fn_t fn [4]);
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < PORT_W; i++) begin
            m[i] = (fn[i] == TNP_FN_IO);
        end
        return m;
    endfunction : io_mask

    // Read mux: inputs give pin, outputs give latch
    function automatic logic [3:0] rd_mux(input logic [3:0] d,
            input logic [3:0] l, input logic [3:0] p, input logic [3:0] m);
        return ((d & l) | (~d & p)) & m;
    endfunction : rd_mux

    assign io_a = io_mask(FN_A);
    assign io_b = io_mask(FN_B);
    assign io_c = io_mask(FN_C);
    assign hold_present = HOLD_C_OPT & PULL_C_EN;

    // Two-stage pin synchronisers; first stage read only by second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {sa1_reg, sa2_reg, sb1_reg, sb2_reg} <= 16'h0000;
            {sc1_reg, sc2_reg} <= 8'h00;
        end else begin
            sa1_reg <= pin_a_in;
            sa2_reg <= sa1_reg;
            sb1_reg <= pin_b_in;
            sb2_reg <= sb1_reg;
            sc1_reg <= pin_c_in;
            sc2_reg <= sc1_reg;
        end
    end

    // Direction and pull state per port
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_a_reg <= DIR_RESET;
            dir_b_reg <= DIR_RESET;
            dir_c_reg <= DIR_RESET;
            pull_a_reg <= PULL_RESET;
            pull_b_reg <= PULL_RESET;
            pull_c_reg <= PULL_RESET;
        end else begin
            if (port_a_config) begin
                dir_a_reg <= cfg_data[3:0];
                pull_a_reg <= cfg_data[CFG_PULL_BIT];
            end
            if (port_b_config) begin
                dir_b_reg <= cfg_data[3:0];
                pull_b_reg <= cfg_data[CFG_PULL_BIT];
            end
            if (port_c_config) begin
                dir_c_reg <= cfg_data[3:0];
                pull_c_reg <= cfg_data[CFG_PULL_BIT];
            end
        end
    end

    // Output latches; oscillator bit frozen against port A writes while converter counts, serial emit still loads it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lat_a_reg <= LATCH_RESET;
            lat_b_reg <= LATCH_RESET;
            lat_c_reg <= LATCH_RESET;
        end else begin
            if (port_a_serial_emit) begin
                lat_a_reg[SER_DATA0] <= ser_data[0];
                lat_a_reg[SER_DATA1] <= ser_data[1];
                lat_a_reg[SER_CONST] <= ser_const;
            end else if (port_a_write) begin
                for (int i = 0; i < PORT_W; i++) begin
                    if (!(i == OSC_BIT && converter_en)) begin
                        lat_a_reg[i] <= wr_data[i];
                    end
                end
            end
            if (port_b_write) begin
                lat_b_reg <= wr_data;
            end
            if (port_c_write) begin
                lat_c_reg <= wr_data;
            end
        end
    end

    // Serial clock pulses for one cycle, in the same cycle the serial data reaches the latch
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ser_clk_reg <= 1'b0;
        end else begin
            ser_clk_reg <= port_a_serial_emit;
        end
    end

    // Pin drive; serial clock is ORed onto latch bit 3 while pulsing
    always_comb begin
        pin_a_out = lat_a_reg & io_a;
        pin_a_out[SER_CLK] = (lat_a_reg[SER_CLK] | ser_clk_reg)
            & io_a[SER_CLK];
        pin_a_oe = dir_a_reg & io_a;
        pin_b_out = lat_b_reg & io_b;
        pin_b_oe = dir_b_reg & io_b;
        pin_c_out = lat_c_reg & io_c;
        pin_c_oe = dir_c_reg & io_c;
    end

    // Pull devices, off on output bits and on non-port pins
    assign pull_a_on = {4{PULL_A_EN & pull_a_reg}} & ~dir_a_reg & io_a;
    assign pull_b_on = {4{PULL_B_EN & pull_b_reg}} & ~dir_b_reg & io_b;
    assign pull_c_on = {4{PULL_C_EN & pull_c_reg}} & ~dir_c_reg & io_c;
    assign hold_c_on = {4{hold_present & ~pull_c_reg}} & ~dir_c_reg
        & io_c;

    // Read values: registered data path
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_a <= 4'h0;
            rd_b <= 4'h0;
            rd_c <= 4'h0;
        end else begin
            rd_a <= rd_mux(dir_a_reg, lat_a_reg, sa2_reg, io_a);
            rd_b <= rd_mux(dir_b_reg, lat_b_reg, sb2_reg, io_b);
            rd_c <= rd_mux(dir_c_reg, lat_c_reg, sc2_reg, io_c);
        end
    end

    // Debounce: change must persist two ticks; clock stops while flag set
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            deb_ref_reg <= 4'h0;
            deb_cnt_reg <= 2'h0;
            debounce_release_flag <= 1'b0;
        end else begin
            if (debounce_tick && !debounce_release_flag) begin
                if (((sc2_reg ^ deb_ref_reg) & debounce_sel & io_c) == 4'h0)
                begin
                    deb_cnt_reg <= 2'h0;
                end else if (deb_cnt_reg == 2'(DEB_STABLE - 1)) begin
                    debounce_release_flag <= 1'b1;
                    deb_ref_reg <= sc2_reg;
                    deb_cnt_reg <= 2'h0;
                end else begin
                    deb_cnt_reg <= deb_cnt_reg + 2'h1;
                end
            end else if (debounce_clear) begin
                debounce_release_flag <= 1'b0; // Set wins over clear
            end
        end
    end

    // Checks
    a_reset_input: assert property (@(posedge clk)
        !rst_n |=> (pin_a_oe | pin_b_oe | pin_c_oe) == 4'h0)
        else $error("ports not input after reset");
    a_cfg_dir: assert property (@(posedge clk) disable iff (!rst_n)
        port_b_config |=> pin_b_oe == ($past(cfg_data[3:0]) & io_b))
        else $error("direction not taken");
    a_write_latch: assert property (@(posedge clk) disable iff (!rst_n)
        port_c_write |=> pin_c_out == ($past(wr_data) & io_c))
        else $error("latch not loaded");
    a_read_out: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> ((rd_b ^ $past(lat_b_reg)) & $past(dir_b_reg) & io_b)
        == 4'h0)
        else $error("output read not latch");
    a_pull_out_off: assert property (@(posedge clk) disable iff (!rst_n)
        ((pull_c_on | hold_c_on) & pin_c_oe) == 4'h0)
        else $error("pull on output bit");
    a_hold_pair: assert property (@(posedge clk) disable iff (!rst_n)
        (hold_c_on & pull_c_on) == 4'h0)
        else $error("pull and hold both on");
    a_osc_frozen: assert property (@(posedge clk) disable iff (!rst_n)
        port_a_write && !port_a_serial_emit && converter_en
        |=> lat_a_reg[OSC_BIT] == $past(lat_a_reg[OSC_BIT]))
        else $error("oscillator latch changed");
    a_ser_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        port_a_serial_emit ##1 !port_a_serial_emit |=> !ser_clk_reg)
        else $error("serial clock too long");
    a_ser_data: assert property (@(posedge clk) disable iff (!rst_n)
        port_a_serial_emit |=> lat_a_reg[SER_CONST] == $past(ser_const)
        ##0 ser_clk_reg)
        else $error("serial bits wrong");
    a_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
        debounce_release_flag && !debounce_clear
        |=> debounce_release_flag)
        else $error("flag dropped");
    c_serial: cover property (@(posedge clk) port_a_serial_emit);
    c_release: cover property (@(posedge clk) $rose(debounce_release_flag));
    c_hold: cover property (@(posedge clk) hold_c_on != 4'h0);
endmodule : tnp_ports
`default_nettype wire

//--- tb/tb_three_nibble_io_ports.sv
// Purpose: self-checking bench for the three-nibble port block
// Assumes: main instance has all pins in port function, all pull options built in
// Notes: driver queues expectations, a watcher compares them
`timescale 1ns/1ps
`default_nettype none
module tb_three_nibble_io_ports;
    import tnp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [8:0] stb = 9'h000;
    logic [4:0] cfg_data = 5'h00;
    logic [3:0] wr_data = 4'h0;
    logic [1:0] ser_data = 2'h0;
    logic ser_const = 1'b0;
    logic converter_en = 1'b0;
    logic [3:0] debounce_sel = 4'h0;
    logic [11:0] ext_en = 12'hfff;
    logic [11:0] ext_val = 12'h000;
    logic [11:0] pins;
    logic [3:0] pin_a_out, pin_b_out, pin_c_out, pin_a_oe, pin_b_oe;
    logic [3:0] pin_c_oe, pull_a_on, pull_b_on, pull_c_on, hold_c_on;
    logic [3:0] rd_a, rd_b, rd_c, e, l, d, v;
    logic debounce_release_flag, c;
    logic [3:0] opt_a_oe, opt_rd_a, opt_hold_c;
    string nm[17] = '{"a_oe", "a_out", "a_rd", "a_pull", "b_oe", "b_out",
        "b_rd", "b_pull", "c_oe", "c_out", "c_rd", "c_pull", "c_hold",
        "flag", "opt_a_oe", "opt_a_rd", "opt_c_hold"};
    logic [31:0] rs = 32'h0a4e;
    logic [3:0] exp_q[$];
    int sel_q[$];
    int err_total = 0;
    int check_count = 0;
    int s;
    event got;
    always #4 clk = ~clk;
    tnp_ports uut (.clk, .rst_n, .cfg_data, .port_a_config(stb[0]),
        .port_b_config(stb[1]), .port_c_config(stb[2]), .wr_data,
        .port_a_write(stb[3]), .port_b_write(stb[4]),
        .port_c_write(stb[5]), .port_a_serial_emit(stb[6]), .ser_data,
        .ser_const, .converter_en, .debounce_tick(stb[7]),
        .debounce_clear(stb[8]), .debounce_sel, .pin_a_in(pins[3:0]),
        .pin_b_in(pins[7:4]), .pin_c_in(pins[11:8]), .pin_a_out,
        .pin_b_out, .pin_c_out, .pin_a_oe, .pin_b_oe, .pin_c_oe,
        .pull_a_on, .pull_b_on, .pull_c_on, .hold_c_on, .rd_a, .rd_b,
        .rd_c, .debounce_release_flag);
    // Option build: A bit 1 on alternate function, no port C pull-low
    tnp_ports #(.FN_A('{TNP_FN_IO, TNP_FN_ALT, TNP_FN_IO, TNP_FN_IO}),
        .PULL_C_EN(1'b0)) opt (.clk, .rst_n, .cfg_data,
        .port_a_config(stb[0]), .port_b_config(stb[1]),
        .port_c_config(stb[2]), .wr_data, .port_a_write(stb[3]),
        .port_b_write(stb[4]), .port_c_write(stb[5]),
        .port_a_serial_emit(stb[6]), .ser_data, .ser_const, .converter_en,
        .debounce_tick(stb[7]), .debounce_clear(stb[8]), .debounce_sel,
        .pin_a_in(pins[3:0]), .pin_b_in(pins[7:4]), .pin_c_in(pins[11:8]),
        .pin_a_out(), .pin_b_out(), .pin_c_out(), .pin_a_oe(opt_a_oe),
        .pin_b_oe(), .pin_c_oe(), .pull_a_on(), .pull_b_on(), .pull_c_on(),
        .hold_c_on(opt_hold_c), .rd_a(opt_rd_a), .rd_b(), .rd_c(),
        .debounce_release_flag());
    tnp_board board (.clk, .oe({pin_c_oe, pin_b_oe, pin_a_oe}),
        .dout({pin_c_out, pin_b_out, pin_a_out}),
        .pull({pull_c_on | hold_c_on, pull_b_on, pull_a_on}), .ext_en,
        .ext_val, .pin(pins));
    // Output by code: port*4 + oe/out/rd/pull, 12 hold, 13 flag, 14-16 opt
    function automatic logic [3:0] seen(int k);
        logic [3:0] t[17];
        t = '{pin_a_oe, pin_a_out, rd_a, pull_a_on, pin_b_oe, pin_b_out,
            rd_b, pull_b_on, pin_c_oe, pin_c_out, rd_c, pull_c_on,
            hold_c_on, {3'h0, debounce_release_flag}, opt_a_oe, opt_rd_a,
            opt_hold_c};
        return t[k];
    endfunction : seen
    function automatic logic [3:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[3:0];
    endfunction : rnd
    task automatic chk(int k, logic [3:0] x);
        sel_q.push_back(k);
        exp_q.push_back(x);
        ->got;
    endtask : chk
    // One-cycle strobe with its operand, launched at a rising edge
    task automatic op(int i, logic [4:0] x);
        @(posedge clk);
        stb[i] <= 1'b1;
        cfg_data <= x;
        wr_data <= x[3:0];
        @(posedge clk);
        stb[i] <= 1'b0;
    endtask : op
    task automatic wait_neg(int n);
        repeat (n) @(negedge clk);
    endtask : wait_neg
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    // Watcher drains every queued note in the step it is told
    always begin
        @(got);
        while (exp_q.size() > 0) begin
            s = sel_q.pop_front();
            e = exp_q.pop_front();
            check_count++;
            if (seen(s) !== e) begin
                err_total++;
                $display("BAD %s exp %h got %h", nm[s], e, seen(s));
            end
        end
    end
    // Watchdog sized well beyond the whole sequence
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        wait_neg(1);
        for (int p = 0; p < 3; p++) chk(p * 4, 4'h0);
        chk(11, 4'hf);
        chk(12, 4'h0);
        $display("test reset done");
        for (int p = 0; p < 3; p++) begin
            for (int n = 0; n < 4; n++) begin
                l = rnd();
                d = rnd();
                v = rnd();
                c = n[0];
                op(3 + p, {1'b0, l});
                op(p, {c, d});
                ext_val[p * 4 +: 4] <= v;
                wait_neg(6);
                chk(p * 4, d);
                chk(p * 4 + 1, l);
                chk(p * 4 + 2, (l & d) | (v & ~d));
                if (p == 2) begin
                    chk(11, c ? ~d : 4'h0);
                    chk(12, c ? 4'h0 : ~d);
                end else chk(p * 4 + 3, c ? ~d : 4'h0);
                if (p == 0) begin
                    chk(14, d & 4'hd);
                    chk(15, ((l & d) | (v & ~d)) & 4'hd);
                end
            end
        end
        $display("test direction latch read done");
        op(2, CFG_C_HOLD);
        ext_en[11:8] <= 4'h0;
        wait_neg(6);
        chk(12, 4'hf);
        chk(11, 4'h0);
        chk(16, 4'h0);
        op(2, CFG_C_PULL);
        wait_neg(6);
        chk(11, 4'hf);
        chk(12, 4'h0);
        chk(10, 4'h0);
        $display("test port c pull hold done");
        op(3, 5'h00);
        op(0, 5'h0f);
        ser_data <= 2'b10;
        ser_const <= 1'b1;
        op(6, 5'h00);
        wait_neg(1);
        chk(1, 4'he);
        wait_neg(1);
        chk(1, 4'h6);
        @(posedge clk) converter_en <= 1'b1;
        op(3, 5'h00);
        wait_neg(1);
        chk(1, 4'h2);
        @(posedge clk) converter_en <= 1'b0;
        $display("test serial converter done");
        @(posedge clk) begin
            ext_en[11:8] <= 4'hf;
            ext_val[11:8] <= 4'h1;
            debounce_sel <= 4'h1;
        end
        wait_neg(5);
        op(7, 5'h00);
        op(7, 5'h00);
        wait_neg(2);
        chk(13, 4'h1);
        op(8, 5'h00);
        wait_neg(2);
        chk(13, 4'h0);
        $display("test debounce done");
        wait_neg(1);
        tally_and_finish();
    end
endmodule : tb_three_nibble_io_ports
`default_nettype wire

//--- tb/tnp_board.sv
// Purpose: board circuitry on the three port pin groups
// Assumes: pins packed {C,B,A}, four bits each
// Notes: an undriven pin without pull toggles so no stale value sticks
`timescale 1ns/1ps
`default_nettype none
module tnp_board (
    input wire logic clk, // Core clock
    input wire logic [11:0] oe, // Device output enables
    input wire logic [11:0] dout, // Device drive values
    input wire logic [11:0] pull, // Pull-low or hold active
    input wire logic [11:0] ext_en, // Board drives the pin
    input wire logic [11:0] ext_val, // Board drive level
    output logic [11:0] pin // Resolved wire level
);
    logic [11:0] float_reg = 12'h000;
    // Floating pattern changes every cycle
    always @(posedge clk) begin
        float_reg <= ~float_reg;
    end
    // Device wins, then board, then pull-low, else floating
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (oe[i]) pin[i] = dout[i];
            else if (ext_en[i]) pin[i] = ext_val[i];
            else if (pull[i]) pin[i] = 1'b0;
            else pin[i] = float_reg[i];
        end
    end
endmodule : tnp_board
`default_nettype wire
